// file: flash_write_ctl.sv
// Flash self-programming control: registers, key lock, write and erase.
//
// Notes on behaviour
// - Write enable sends move writes to flash.
// - Erase plus write enable erases page.
// - Erase ignores the written data byte.
// - Scratchpad select redirects reads and writes.
// - Upper five control bits read zero.
// - One-shot pulses sense amps per access.
// - One-shot on at reset, bypass bit.
// - Third fetch after unbypass is indeterminate.
// - Rows of 128 bytes; crossing flagged.
// - Interrupts held until flash operation ends.
// - Two keys unlock one write or erase.
// - Bad key or locked attempt disables writes.
// - Key register reads lock state code.
// - Flash write with supply monitor off gives error reset.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctl_defines.svh"
module flash_write_ctl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic xdata_wr,
    input wire logic [15:0] xdata_addr,
    input wire logic [7:0] xdata_wdata,
    input wire logic code_rd,
    input wire logic [15:0] code_addr,
    input wire logic flash_done,
    input wire logic vdd_mon_en,
    input wire logic vdd_rst_en,
    output logic xram_wr,
    output logic flash_program,
    output logic flash_erase,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic scratchpad_sel,
    output logic sense_en,
    output logic row_change,
    output logic fetch_indet,
    output logic cpu_stall,
    output logic irq_hold,
    output logic flash_error_device_reset,
    output flash_ctl_pkg::key_state_t key_state
);
    import flash_ctl_pkg::*;

    logic we_q, ee_q, sp_q, bypass_q;
    logic [1:0] mon_s1_q, mon_s2_q;
    key_state_t key_q, key_d;
    op_state_t op_q;
    logic [15:0] last_row_addr_q;
    logic [1:0] fetch_cnt_q;
    logic indet_armed_q;

    // Register decode and read-back.
    wire wr_psc = sfr_wr && sfr_addr == `PSC_ADDR;
    wire wr_fts = sfr_wr && sfr_addr == `FTS_ADDR;
    wire wr_key = sfr_wr && sfr_addr == `FKEY_ADDR;
    wire [1:0] lock_code = key_q == KEY_FIRST_SEEN ? `LOCK_FIRST :
                           key_q == KEY_OPEN ? `LOCK_OPEN :
                           key_q == KEY_DEAD ? `LOCK_DEAD : `LOCK_LOCKED;
    wire [7:0] psc_rd = {5'h00, sp_q, ee_q, we_q};
    wire [7:0] fts_rd = {1'b0, bypass_q, 6'h00};
    wire [7:0] key_rd = {6'h00, lock_code};
    wire [7:0] rdata_d = sfr_addr == `PSC_ADDR ? psc_rd :
                         sfr_addr == `FTS_ADDR ? fts_rd :
                         sfr_addr == `FKEY_ADDR ? key_rd : 8'h00;

    // Monitor levels come from another block's pins, so they are synced.
    wire vdd_ok = &mon_s2_q;
    wire idle = op_q == OP_IDLE;
    wire fl_wr = idle && xdata_wr && we_q;
    wire fl_go = fl_wr && key_q == KEY_OPEN && vdd_ok;
    wire fl_fault = fl_wr && !vdd_ok;
    wire fl_refuse = fl_wr && vdd_ok && key_q != KEY_OPEN;

    always_comb begin
        key_d = key_q;
        unique case (key_q)
            KEY_LOCKED: begin
                if (wr_key) begin
                    key_d = sfr_wdata == `KEY_FIRST ? KEY_FIRST_SEEN : KEY_DEAD;
                end
            end
            KEY_FIRST_SEEN: begin
                if (wr_key) begin
                    key_d = sfr_wdata == `KEY_SECOND ? KEY_OPEN : KEY_DEAD;
                end
            end
            KEY_OPEN: begin
                if (wr_key) begin
                    key_d = KEY_DEAD;
                end else if (op_q == OP_BUSY && flash_done) begin
                    key_d = KEY_LOCKED;
                end
            end
            KEY_DEAD: key_d = KEY_DEAD;
            default: key_d = KEY_DEAD;
        endcase
        if (fl_refuse) begin
            key_d = KEY_DEAD;
        end
    end

    // Control bits; reset leaves the one-shot active and writes disabled.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            {sp_q, ee_q, we_q} <= `PSC_RESET;
            bypass_q <= 1'b0;
        end else begin
            if (wr_psc) begin
                we_q <= sfr_wdata[`PSC_WE_BIT];
                ee_q <= sfr_wdata[`PSC_EE_BIT];
                sp_q <= sfr_wdata[`PSC_SP_BIT];
            end
            if (wr_fts) begin
                bypass_q <= sfr_wdata[`FTS_BYPASS_BIT];
            end
        end
    end

    // Two-stage synchronisers for the supply monitor levels.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mon_s1_q <= 2'h0;
            mon_s2_q <= 2'h0;
        end else begin
            mon_s1_q <= {vdd_rst_en, vdd_mon_en};
            mon_s2_q <= mon_s1_q;
        end
    end

    // Key state and operation sequencer.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            key_q <= KEY_LOCKED;
            op_q <= OP_IDLE;
        end else begin
            key_q <= key_d;
            if (fl_go) begin
                op_q <= OP_BUSY;
            end else if (op_q == OP_BUSY && flash_done) begin
                op_q <= OP_IDLE;
            end
        end
    end

    // Flash command outputs; program and erase are one-cycle strobes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flash_program <= 1'b0;
            flash_erase <= 1'b0;
            flash_addr <= 16'h0000;
            flash_wdata <= 8'h00;
            xram_wr <= 1'b0;
            flash_error_device_reset <= 1'b0;
        end else begin
            flash_erase <= fl_go && ee_q;
            flash_program <= fl_go && !ee_q;
            xram_wr <= xdata_wr && !we_q && idle;
            flash_error_device_reset <= fl_fault;
            if (fl_go || (xdata_wr && !we_q && idle)) begin
                flash_addr <= xdata_addr;
            end
            if (fl_go && !ee_q) begin
                flash_wdata <= xdata_wdata;
            end
        end
    end

    // Status and routing outputs, all registered.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
            scratchpad_sel <= 1'b0;
            cpu_stall <= 1'b0;
            irq_hold <= 1'b0;
            key_state <= KEY_LOCKED;
        end else begin
            sfr_rdata <= rdata_d;
            scratchpad_sel <= sp_q;
            cpu_stall <= fl_go || (op_q == OP_BUSY && !flash_done);
            irq_hold <= fl_go || (op_q == OP_BUSY && !flash_done);
            key_state <= key_d;
        end
    end

    // row crossing
    // Row changes cost read current, so they are reported to power logic.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            last_row_addr_q <= 16'h0000;
            row_change <= 1'b0;
        end else begin
            row_change <= code_rd && code_addr[15:`ROW_LSB] !=
                          last_row_addr_q[15:`ROW_LSB];
            if (code_rd) begin
                last_row_addr_q <= code_addr;
            end
        end
    end

    // third fetch marked
    // The core cannot trust the third opcode fetch after re-enabling.
    wire unbypass = wr_fts && bypass_q && !sfr_wdata[`FTS_BYPASS_BIT];
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            indet_armed_q <= 1'b0;
            fetch_cnt_q <= 2'h0;
            fetch_indet <= 1'b0;
        end else begin
            fetch_indet <= indet_armed_q && code_rd &&
                           fetch_cnt_q == `INDET_FETCH - 2'h1;
            if (unbypass) begin
                indet_armed_q <= 1'b1;
                fetch_cnt_q <= 2'h0;
            end else if (indet_armed_q && code_rd) begin
                fetch_cnt_q <= fetch_cnt_q + 2'h1;
                if (fetch_cnt_q == `INDET_FETCH - 2'h1) begin
                    indet_armed_q <= 1'b0;
                end
            end
        end
    end

    flash_read_oneshot u_oneshot (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bypass(bypass_q),
        .access(code_rd),
        .sense_en(sense_en)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    prog_strobe_a: assert property (
        xdata_wr && we_q && !ee_q && idle && key_q == KEY_OPEN && vdd_ok
        |=> flash_program && !flash_erase)
        else $error("byte program not issued");
    erase_strobe_a: assert property (
        xdata_wr && we_q && ee_q && idle && key_q == KEY_OPEN && vdd_ok
        |=> flash_erase && !flash_program && cpu_stall)
        else $error("page erase not issued");
    erase_data_a: assert property (
        flash_erase |-> $stable(flash_wdata))
        else $error("erase changed write data");
    scratch_route_a: assert property (
        wr_psc |=> ##1 scratchpad_sel == $past(sfr_wdata[`PSC_SP_BIT], 2))
        else $error("scratchpad select wrong");
    upper_zero_a: assert property (
        sfr_addr == `PSC_ADDR |=> sfr_rdata[7:3] == 5'h00)
        else $error("control upper bits not zero");
    sense_bypass_a: assert property (
        bypass_q |=> sense_en)
        else $error("bypass must keep amps on");
    sense_oneshot_a: assert property (
        !bypass_q && !code_rd |=> !sense_en)
        else $error("amps on without access");
    lapse_a: assert property (
        op_q == OP_BUSY && flash_done |=> key_q == KEY_LOCKED && idle)
        else $error("permission did not lapse");
    dead_hold_a: assert property (
        key_q == KEY_DEAD |=> key_q == KEY_DEAD [*4])
        else $error("lockout released before reset");
    lock_code_a: assert property (
        sfr_addr == `FKEY_ADDR && key_q == KEY_FIRST_SEEN
        |=> sfr_rdata == 8'h01)
        else $error("lock code read wrong");
    fault_a: assert property (
        fl_wr && !vdd_ok |=> flash_error_device_reset && !flash_program
        && !flash_erase)
        else $error("supply fault not reported");
    xram_pass_a: assert property (
        xdata_wr && !we_q && idle |=> xram_wr && !flash_program)
        else $error("plain write not passed on");
    irq_stall_a: assert property (
        op_q == OP_BUSY && !flash_done |=> cpu_stall && irq_hold)
        else $error("stall dropped during operation");

    cover_prog_c: cover property (flash_program);
    cover_erase_c: cover property (flash_erase ##[1:20] !cpu_stall);
    cover_dead_c: cover property (key_q == KEY_DEAD);
    cover_indet_c: cover property (fetch_indet);
endmodule
`default_nettype wire

// file: flash_ctl_defines.svh
// Register offsets, field positions, key codes and reset values.
`ifndef FLASH_CTL_DEFINES_SVH
`define FLASH_CTL_DEFINES_SVH
`define PSC_ADDR 8'h8f
`define FTS_ADDR 8'hb6
`define FKEY_ADDR 8'hb7
`define PSC_RESET 3'h0
`define PSC_WE_BIT 0
`define PSC_EE_BIT 1
`define PSC_SP_BIT 2
`define FTS_BYPASS_BIT 6
`define KEY_FIRST 8'ha5
`define KEY_SECOND 8'hf1
`define LOCK_LOCKED 2'h0
`define LOCK_FIRST 2'h1
`define LOCK_OPEN 2'h2
`define LOCK_DEAD 2'h3
`define ROW_LSB 7
`define INDET_FETCH 2'h3
`endif

// file: flash_ctl_pkg.sv
// Types shared by the flash write and erase control block.
package flash_ctl_pkg;
    typedef enum logic [3:0] {
        KEY_LOCKED = 4'h1,
        KEY_FIRST_SEEN = 4'h2,
        KEY_OPEN = 4'h4,
        KEY_DEAD = 4'h8
    } key_state_t;
    typedef enum logic [1:0] {
        OP_IDLE = 2'h1,
        OP_BUSY = 2'h2
    } op_state_t;
endpackage

// file: flash_read_oneshot.sv
// Read timing one-shot that gates the flash sense amplifiers.
`timescale 1ns/1ps
`default_nettype none
module flash_read_oneshot (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic bypass,
    input wire logic access,
    output logic sense_en
);
    // pulse per access
    // With the one-shot active the amps wake only on access cycles; in
    // bypass they stay on and the clock alone sets the read time.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sense_en <= 1'b0;
        end else begin
            sense_en <= bypass | access;
        end
    end
endmodule
`default_nettype wire

// file: flash_array_model.sv
// Behavioural flash array that answers program and erase strobes.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(parameter int DLY = 4) (
    input wire logic clk_sys,
    input wire logic flash_program,
    input wire logic flash_erase,
    output logic flash_done
);
    int cnt = 0;
    // Busy time is shortened; the real array is far slower.
    // done ends stall
    always @(posedge clk_sys) begin
        flash_done <= (cnt == 1);
        if (flash_program || flash_erase) cnt <= DLY;
        else if (cnt > 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// file: program_flash_write_erase_control_tb_top.sv
// Self-checking bench for the flash write and erase control block.
`timescale 1ns/1ps
`default_nettype none
module program_flash_write_erase_control_tb_top;
    import flash_ctl_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} row_t;
    logic clk_sys = 0, rst_n = 0, sfr_wr = 0, xdata_wr = 0, code_rd = 0;
    logic vdd_mon_en = 1, vdd_rst_en = 1, flash_done, seen_r, seen_f;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, xdata_wdata = 0;
    logic [7:0] sfr_rdata, flash_wdata;
    logic [15:0] xdata_addr = 0, code_addr = 0, flash_addr;
    logic xram_wr, flash_program, flash_erase, scratchpad_sel, sense_en;
    logic row_change, fetch_indet, cpu_stall, irq_hold;
    logic flash_error_device_reset;
    key_state_t key_state;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    row_t rows[5] = '{'{8'h8f, 8'hff, 8'h07}, '{8'h8f, 8'h00, 8'h00},
        '{8'hb6, 8'hff, 8'h40}, '{8'hb6, 8'h00, 8'h00},
        '{8'h90, 8'hff, 8'h00}};

    flash_write_ctl dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
        .xdata_wdata(xdata_wdata), .code_rd(code_rd), .code_addr(code_addr),
        .flash_done(flash_done), .vdd_mon_en(vdd_mon_en),
        .vdd_rst_en(vdd_rst_en), .xram_wr(xram_wr),
        .flash_program(flash_program), .flash_erase(flash_erase),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .scratchpad_sel(scratchpad_sel), .sense_en(sense_en),
        .row_change(row_change), .fetch_indet(fetch_indet),
        .cpu_stall(cpu_stall), .irq_hold(irq_hold),
        .flash_error_device_reset(flash_error_device_reset),
        .key_state(key_state));
    flash_array_model array (.clk_sys(clk_sys),
        .flash_program(flash_program), .flash_erase(flash_erase),
        .flash_done(flash_done));

    // Clock and a cycle ceiling that cuts a hang short.
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_key(key_state_t e);
        n_checks++;
        if (key_state !== e) begin
            n_mismatch++;
            $display("MISMATCH key_state expected %h seen %h", e, key_state);
        end
    endtask
    // Every driver enters just after an edge and leaves just after one.
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic sfr_write(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        tick();
        sfr_wr = 0;
        // An idle edge keeps two writes from meeting in one time step.
        tick();
    endtask
    task automatic sfr_chk(logic [7:0] a, logic [7:0] e);
        sfr_addr = a;
        tick();
        chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata});
    endtask
    task automatic xwrite(logic [15:0] a, logic [7:0] d);
        xdata_addr = a;
        xdata_wdata = d;
        xdata_wr = 1;
        tick();
        xdata_wr = 0;
    endtask
    // Pulse flags are gathered over two cycles so either latency passes.
    task automatic code(logic [15:0] a);
        code_addr = a;
        code_rd = 1;
        tick();
        code_rd = 0;
        seen_r = row_change;
        seen_f = fetch_indet;
        tick();
        seen_r = seen_r | row_change;
        seen_f = seen_f | fetch_indet;
        tick();
    endtask
    task automatic unlock();
        sfr_write(8'hb7, 8'ha5);
        sfr_write(8'hb7, 8'hf1);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 30 && cpu_stall !== 1'b0; i++) tick();
        chk("cpu_stall", 16'h0, {15'h0, cpu_stall});
    endtask
    task automatic do_reset();
        rst_n = 0;
        tick(12);
        rst_n = 1;
        tick(3);
    endtask

    // Register rows first, then the sequenced cases.
    initial begin
        do_reset();
        chk_key(KEY_LOCKED);
        chk("sense_en", 16'h0, {15'h0, sense_en});
        foreach (rows[i]) begin
            sfr_write(rows[i].a, rows[i].w);
            sfr_chk(rows[i].a, rows[i].r);
        end
        code_rd = 1;
        tick();
        code_rd = 0;
        chk("sense_en", 16'h1, {15'h0, sense_en});
        tick();
        chk("sense_en", 16'h0, {15'h0, sense_en});
        sfr_write(8'hb6, 8'h40);
        tick();
        chk("sense_en", 16'h1, {15'h0, sense_en});
        sfr_write(8'hb6, 8'h00);
        code(16'h0010);
        chk("fetch_indet", 16'h0, {15'h0, seen_f});
        code(16'h007f);
        chk("row_change", 16'h0, {15'h0, seen_r});
        code(16'h0080);
        chk("fetch_indet", 16'h1, {15'h0, seen_f});
        chk("row_change", 16'h1, {15'h0, seen_r});
        xwrite(16'h4000, 8'h3c);
        chk("xram_wr", 16'h1, {15'h0, xram_wr});
        chk("flash_program", 16'h0, {15'h0, flash_program});
        chk("flash_addr", 16'h4000, flash_addr);
        sfr_write(8'h8f, 8'h04);
        tick();
        chk("scratchpad_sel", 16'h1, {15'h0, scratchpad_sel});
        code(16'h03ff);
        chk("row_change", 16'h1, {15'h0, seen_r});
        sfr_write(8'hb7, 8'ha5);
        sfr_chk(8'hb7, 8'h01);
        sfr_write(8'hb7, 8'hf1);
        sfr_chk(8'hb7, 8'h02);
        sfr_write(8'h8f, 8'h03);
        xwrite(16'h1234, 8'h77);
        chk("flash_erase", 16'h1, {15'h0, flash_erase});
        chk("flash_program", 16'h0, {15'h0, flash_program});
        chk("flash_addr", 16'h1234, flash_addr);
        chk("flash_wdata", 16'h00, {8'h0, flash_wdata});
        wait_idle();
        chk_key(KEY_LOCKED);
        unlock();
        sfr_write(8'h8f, 8'h01);
        xwrite(16'h1234, 8'h5a);
        chk("flash_program", 16'h1, {15'h0, flash_program});
        chk("flash_erase", 16'h0, {15'h0, flash_erase});
        chk("flash_wdata", 16'h5a, {8'h0, flash_wdata});
        chk("flash_addr", 16'h1234, flash_addr);
        chk("irq_hold", 16'h1, {15'h0, irq_hold});
        chk("cpu_stall", 16'h1, {15'h0, cpu_stall});
        wait_idle();
        chk_key(KEY_LOCKED);
        xwrite(16'h1400, 8'h11);
        chk("flash_program", 16'h0, {15'h0, flash_program});
        chk("flash_erase", 16'h0, {15'h0, flash_erase});
        sfr_chk(8'hb7, 8'h03);
        do_reset();
        vdd_mon_en = 0;
        tick(3);
        unlock();
        sfr_write(8'h8f, 8'h01);
        xwrite(16'h1234, 8'h00);
        chk("error_reset", 16'h1, {15'h0, flash_error_device_reset});
        chk("flash_program", 16'h0, {15'h0, flash_program});
        complete_run();
    end
endmodule
`default_nettype wire
